// ### rtl/scd_pkg.sv
/*
 * Shared constants and carrier types of the sample clock divider and
 * delay control block: register offsets, field positions, reset values,
 * divider codes and the serial port frame layout.
 * Assumes one 100 MHz REF_CLK domain and a host on the 3-wire serial port.
 */
`default_nettype none

package scd_pkg;

   // ***********************************************************
   // Register offsets (15-bit serial address space)
   // ***********************************************************
   localparam logic [14:0] ADDR_CHAN_SEL = 15'h0008;
   localparam logic [14:0] ADDR_REF_SEL = 15'h0024;
   localparam logic [14:0] ADDR_FULL_SCALE = 15'h0025;
   localparam logic [14:0] ADDR_DIV_RATIO = 15'h010b;
   localparam logic [14:0] ADDR_HALF_ADJ = 15'h010c;
   localparam logic [14:0] ADDR_FINE_EN = 15'h0117;
   localparam logic [14:0] ADDR_FINE_VAL = 15'h0118;

   // ***********************************************************
   // Field positions
   // ***********************************************************
   localparam int DIV_CODE_LSB = 0;
   localparam int DIV_PRESET_LSB = 4;
   localparam int DIV_SYNC_EN_BIT = 7;
   localparam int REF_EXT_BIT = 0;
   localparam int FINE_EN_BIT = 0;

   // ***********************************************************
   // Reset values
   // ***********************************************************
   localparam logic [1:0] RST_CHAN_SEL = 2'h3;
   localparam logic [7:0] RST_REF_SEL = 8'h00;
   localparam logic [7:0] RST_FULL_SCALE = 8'h00;
   localparam logic [7:0] RST_DIV_RATIO = 8'h00;
   localparam logic [1:0] RST_HALF_ADJ = 2'h0;
   localparam logic [1:0] RST_FINE_EN = 2'h0;
   localparam logic [7:0] RST_FINE_VAL = 8'h00;

   // ***********************************************************
   // Divider codes and serial frame
   // ***********************************************************
   localparam logic [1:0] DIV_BY_1 = 2'h0;
   localparam logic [1:0] DIV_BY_2 = 2'h1;
   localparam logic [1:0] DIV_BY_4 = 2'h2;
   localparam logic [1:0] DIV_BY_8 = 2'h3;
   localparam int NUM_CHAN = 2;
   localparam logic [4:0] SPI_INSTR_BITS = 5'h10;
   localparam logic [4:0] SPI_FRAME_BITS = 5'h18;

   typedef struct packed {
      logic valid;
      logic [14:0] addr;
      logic [7:0] data;
   } scd_wr_t;

   typedef struct packed {
      logic [1:0] enable;
      logic [7:0] value_b;
      logic [7:0] value_a;
   } scd_fine_t;

endpackage

`default_nettype wire

// ### rtl/scd_spi_slave.sv
/*
 * Serial configuration port slave: 16-bit instruction (read flag, 15-bit
 * address) then one data byte, MSB first, sampled on rising SCLK.
 * Assumes SCLK and CSB are synchronous to REF_CLK and at least four times
 * slower, so every SCLK edge is seen as a level change between two cycles.
 */
`default_nettype none

module scd_spi_slave
   import scd_pkg::*;
(
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Serial pins
   input wire logic sclk,
   input wire logic csb_n,
   input wire logic sdio_in,
   output logic sdio_out,
   output logic sdio_oe,
   // Register side
   output scd_wr_t wr,
   output logic [14:0] rd_addr,
   input wire logic [7:0] rd_data
);

   logic sclk_reg;
   logic [4:0] cnt_reg;
   logic [23:0] sh_reg;
   logic [7:0] out_reg;
   logic load_reg;
   logic rd_flag_reg;
   scd_wr_t wr_reg;
   wire rise = sclk & ~sclk_reg;
   wire fall = ~sclk & sclk_reg;
   // Held from the 16th bit, since data-phase shifts move the flag out of place
   wire is_read = rd_flag_reg;
   wire data_phase = (cnt_reg >= SPI_INSTR_BITS);
   wire [23:0] sh_next = {sh_reg[22:0], sdio_in};
   wire [4:0] cnt_next = cnt_reg + 5'h01;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_reg <= 1'b0;
         cnt_reg <= 5'h00;
         sh_reg <= 24'h000000;
         out_reg <= 8'h00;
         load_reg <= 1'b0;
         rd_flag_reg <= 1'b0;
         wr_reg <= '0;
      end else if (ce) begin
         sclk_reg <= sclk;
         load_reg <= 1'b0;
         wr_reg.valid <= 1'b0;
         if (csb_n) begin
            cnt_reg <= 5'h00;
         end else if (rise && cnt_reg < SPI_FRAME_BITS) begin
            sh_reg <= sh_next;
            cnt_reg <= cnt_next;
            load_reg <= (cnt_next == SPI_INSTR_BITS);
            if (cnt_next == SPI_INSTR_BITS) begin
               rd_flag_reg <= sh_next[15];
            end
            // A write frame commits on its 24th bit only
            if (cnt_next == SPI_FRAME_BITS && !sh_next[23]) begin
               wr_reg <= '{valid: 1'b1, addr: sh_next[22:8], data: sh_next[7:0]};
            end
         end else if (load_reg) begin
            out_reg <= rd_data;
         end else if (fall && cnt_reg > SPI_INSTR_BITS) begin
            out_reg <= {out_reg[6:0], 1'b0};
         end
      end
   end

   assign rd_addr = sh_reg[14:0];
   assign wr = wr_reg;
   assign sdio_out = out_reg[7];
   assign sdio_oe = ~csb_n & is_read & data_phase & ~load_reg;

endmodule

`default_nettype wire

// ### rtl/scd_clock_ctrl.sv
/*
 * Sample clock divider and delay control: clock divider with sync preset,
 * per-channel half-period and fine delay settings, reference and full-scale
 * selection, all programmed over the 3-wire serial port.
 * Assumes REF_CLK stands for the input sample clock; the analog delay lines,
 * reference buffer and converter core sit outside and take these controls.
 */
`default_nettype none

module scd_clock_ctrl
   import scd_pkg::*;
(
   // Clock, reset, enable
   input wire logic REF_CLK,
   input wire logic RESET_N,
   input wire logic CLK_EN,
   // Sync event
   input wire logic SYSREF,
   // Serial configuration port
   input wire logic SPI_SCLK,
   input wire logic SPI_CSB_N,
   input wire logic SPI_SDIO_IN,
   output logic SPI_SDIO_OUT,
   output logic SPI_SDIO_OE,
   // Divided clock
   output logic DIV_CLK,
   output logic DIV_CE,
   // Per-channel delay controls
   output logic [1:0] HALF_DLY,
   output scd_fine_t FINE_DLY,
   output logic [1:0] DP_RESET,
   // Reference and range
   output logic REF_EXT,
   output logic [7:0] FULL_SCALE
);

   // ***********************************************************
   // Decode helpers
   // ***********************************************************
   function automatic logic [2:0] ratio_mask(input logic [1:0] code);
      case (code)
         DIV_BY_1: ratio_mask = 3'h0;
         DIV_BY_2: ratio_mask = 3'h1;
         DIV_BY_4: ratio_mask = 3'h3;
         DIV_BY_8: ratio_mask = 3'h7;
         default: ratio_mask = 3'h0;
      endcase
   endfunction

   // Top count bit of the active ratio; set in the second half of the period, where DIV_CLK is low
   function automatic logic upper_half(input logic [1:0] code, input logic [2:0] cnt);
      case (code)
         DIV_BY_2: upper_half = cnt[0];
         DIV_BY_4: upper_half = cnt[1];
         DIV_BY_8: upper_half = cnt[2];
         default: upper_half = 1'b0;
      endcase
   endfunction

   // ***********************************************************
   // Serial port
   // ***********************************************************
   scd_wr_t wr;
   logic [14:0] rd_addr;
   logic [7:0] rd_data;

   scd_spi_slave u_spi (
      .clk(REF_CLK),
      .rst_n(RESET_N),
      .ce(CLK_EN),
      .sclk(SPI_SCLK),
      .csb_n(SPI_CSB_N),
      .sdio_in(SPI_SDIO_IN),
      .sdio_out(SPI_SDIO_OUT),
      .sdio_oe(SPI_SDIO_OE),
      .wr(wr),
      .rd_addr(rd_addr),
      .rd_data(rd_data)
   );

   // ***********************************************************
   // Register file
   // ***********************************************************
   logic [1:0] chan_sel_reg;
   logic [7:0] ref_sel_reg;
   logic [7:0] full_scale_reg;
   logic [7:0] div_ratio_reg;
   logic [1:0] half_adj_reg;
   logic [1:0] fine_en_reg;
   logic [7:0] fine_val_reg [NUM_CHAN];
   logic [1:0] dp_reset_reg;

   wire wr_chan_sel = wr.valid && wr.addr == ADDR_CHAN_SEL;
   wire wr_ref_sel = wr.valid && wr.addr == ADDR_REF_SEL;
   wire wr_full_scale = wr.valid && wr.addr == ADDR_FULL_SCALE;
   wire wr_div_ratio = wr.valid && wr.addr == ADDR_DIV_RATIO;
   wire wr_half_adj = wr.valid && wr.addr == ADDR_HALF_ADJ;
   wire wr_fine_en = wr.valid && wr.addr == ADDR_FINE_EN;
   wire wr_fine_val = wr.valid && wr.addr == ADDR_FINE_VAL;

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         chan_sel_reg <= RST_CHAN_SEL;
         ref_sel_reg <= RST_REF_SEL;
         full_scale_reg <= RST_FULL_SCALE;
         div_ratio_reg <= RST_DIV_RATIO;
         half_adj_reg <= RST_HALF_ADJ;
      end else if (CLK_EN) begin
         if (wr_chan_sel) begin
            chan_sel_reg <= wr.data[1:0];
         end
         if (wr_ref_sel) begin
            ref_sel_reg <= wr.data;
         end
         if (wr_full_scale) begin
            full_scale_reg <= wr.data;
         end
         if (wr_div_ratio) begin
            div_ratio_reg <= wr.data;
         end
         // Only the delay select moves; divider and link state are untouched
         if (wr_half_adj) begin
            half_adj_reg <= wr.data[1:0];
         end
      end
   end

   // ***********************************************************
   // Per-channel fine delay
   // ***********************************************************
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CHAN; ch = ch + 1) begin : g_chan
         wire sel = chan_sel_reg[ch];
         wire set_en = wr_fine_en && sel && wr.data[FINE_EN_BIT];
         // Reset only on the off-to-on edge of the enable
         wire fire = set_en && !fine_en_reg[ch];

         always_ff @(posedge REF_CLK or negedge RESET_N) begin
            if (!RESET_N) begin
               fine_en_reg[ch] <= RST_FINE_EN[ch];
               fine_val_reg[ch] <= RST_FINE_VAL;
               dp_reset_reg[ch] <= 1'b0;
            end else if (CLK_EN) begin
               dp_reset_reg[ch] <= fire;
               if (wr_fine_en && sel) begin
                  fine_en_reg[ch] <= wr.data[FINE_EN_BIT];
               end
               if (wr_fine_val && sel) begin
                  fine_val_reg[ch] <= wr.data;
               end
            end
         end
      end
   endgenerate

   // Active on the cycle after the enabling write, no commit step
   assign FINE_DLY.enable = fine_en_reg;
   assign FINE_DLY.value_a = fine_en_reg[0] ? fine_val_reg[0] : 8'h00;
   assign FINE_DLY.value_b = fine_en_reg[1] ? fine_val_reg[1] : 8'h00;
   assign DP_RESET = dp_reset_reg;
   assign HALF_DLY = half_adj_reg;
   assign REF_EXT = ref_sel_reg[REF_EXT_BIT];
   assign FULL_SCALE = full_scale_reg;

   // ***********************************************************
   // Read back
   // ***********************************************************
   // Channel registers read the lowest selected channel
   wire rd_ch = ~chan_sel_reg[0];
   wire [7:0] fine_en_rd = {7'h00, fine_en_reg[rd_ch]};

   assign rd_data = (rd_addr == ADDR_CHAN_SEL) ? {6'h00, chan_sel_reg} :
                    (rd_addr == ADDR_REF_SEL) ? ref_sel_reg :
                    (rd_addr == ADDR_FULL_SCALE) ? full_scale_reg :
                    (rd_addr == ADDR_DIV_RATIO) ? div_ratio_reg :
                    (rd_addr == ADDR_HALF_ADJ) ? {6'h00, half_adj_reg} :
                    (rd_addr == ADDR_FINE_EN) ? fine_en_rd :
                    (rd_addr == ADDR_FINE_VAL) ? fine_val_reg[rd_ch] :
                    8'h00;

   // ***********************************************************
   // Clock divider
   // ***********************************************************
   // The ratio is assumed stable before the clock runs; a change on the fly
   // just re-masks the count and may give one short period
   logic [2:0] cnt_reg;
   logic sysref_reg;
   logic div_clk_reg;
   logic div_ce_reg;

   wire [1:0] div_code = div_ratio_reg[DIV_CODE_LSB +: 2];
   wire [2:0] div_preset = div_ratio_reg[DIV_PRESET_LSB +: 3];
   wire sync_en = div_ratio_reg[DIV_SYNC_EN_BIT];
   wire [2:0] mask = ratio_mask(div_code);
   wire sysref_edge = SYSREF & ~sysref_reg;
   wire sync_load = sysref_edge & sync_en;
   wire [2:0] cnt_inc = cnt_reg + 3'h1;
   // Preset lands on this edge and counting resumes on the next one
   wire [2:0] cnt_next = sync_load ? (div_preset & mask) : (cnt_inc & mask);

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         cnt_reg <= 3'h0;
         sysref_reg <= 1'b0;
         div_clk_reg <= 1'b0;
         div_ce_reg <= 1'b0;
      end else if (CLK_EN) begin
         sysref_reg <= SYSREF;
         cnt_reg <= cnt_next;
         // Equal high and low halves of the count at ratios 2, 4 and 8 (ratio 1 holds it high), independent of input duty
         div_clk_reg <= ~upper_half(div_code, cnt_next);
         div_ce_reg <= (cnt_next == 3'h0);
      end
   end

   assign DIV_CLK = div_clk_reg;
   assign DIV_CE = div_ce_reg;

endmodule

`default_nettype wire

// ### tb/scd_clock_ctrl_asserts.sv
/* Port-level checker for the clock control block.
   Assumes it is bound onto scd_clock_ctrl with every port joined. */
`default_nettype none
module scd_clock_ctrl_asserts
   import scd_pkg::*;
(
   // Clock and control
   input wire logic REF_CLK,
   input wire logic RESET_N,
   input wire logic CLK_EN,
   input wire logic SYSREF,
   // Serial port
   input wire logic SPI_SCLK,
   input wire logic SPI_CSB_N,
   input wire logic SPI_SDIO_IN,
   input wire logic SPI_SDIO_OUT,
   input wire logic SPI_SDIO_OE,
   // Outputs watched
   input wire logic DIV_CLK,
   input wire logic DIV_CE,
   input wire logic [1:0] HALF_DLY,
   input wire scd_fine_t FINE_DLY,
   input wire logic [1:0] DP_RESET,
   input wire logic REF_EXT,
   input wire logic [7:0] FULL_SCALE
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RESET_N);
   // *****
   // Duty helpers: writes and sync events distort one period, so wait for calm
   // *****
   logic [3:0] hi_run, lo_run, hi_last;
   logic [4:0] calm;
   logic [3:0] ce_gap;
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         hi_run <= 4'h0;
         lo_run <= 4'h0;
         hi_last <= 4'h0;
         calm <= 5'h0;
         ce_gap <= 4'h0;
      end else if (CLK_EN) begin
         hi_run <= DIV_CLK ? hi_run + 4'h1 : 4'h0;
         lo_run <= DIV_CLK ? 4'h0 : lo_run + 4'h1;
         if (!DIV_CLK && hi_run != 4'h0) begin
            hi_last <= hi_run;
         end
         calm <= (!SPI_CSB_N || SYSREF) ? 5'h0 : ((calm == 5'h1f) ? calm : calm + 5'h1);
         // Enabled cycles since the last tick; a sync preset may stretch one period
         ce_gap <= (DIV_CE || SYSREF) ? 4'h0 : ((ce_gap == 4'hf) ? ce_gap : ce_gap + 4'h1);
      end
   end
   a_ce_on_high: assert property (DIV_CE |-> DIV_CLK)
      else $error("divider tick outside the high phase");
   a_ce_spacing: assert property (ce_gap < 4'h8)
      else $error("divider tick missing");
   a_duty_balance: assert property ($rose(DIV_CLK) && calm > 5'h14 && hi_last != 4'h0 |-> lo_run == hi_last)
      else $error("divided clock high and low times differ");
   a_fine_pulse: assert property ($past(CLK_EN) |-> DP_RESET == (FINE_DLY.enable & ~$past(FINE_DLY.enable)))
      else $error("datapath reset not tied to fine enable rise");
   a_fine_gated: assert property ((FINE_DLY.enable[0] || FINE_DLY.value_a == 8'h00) &&
      (FINE_DLY.enable[1] || FINE_DLY.value_b == 8'h00))
      else $error("fine value visible while disabled");
   a_cfg_by_frame: assert property ($changed({HALF_DLY, REF_EXT, FULL_SCALE, FINE_DLY}) |-> !$past(SPI_CSB_N))
      else $error("setting changed outside a serial frame");
   a_half_no_reset: assert property ($changed(HALF_DLY) |-> DP_RESET == 2'h0 && $stable(FINE_DLY))
      else $error("half period change disturbed the datapath");
   a_value_no_reset: assert property ($stable(FINE_DLY.enable) && $changed(FINE_DLY) |-> DP_RESET == 2'h0)
      else $error("fine value change reset the datapath");
endmodule

bind scd_clock_ctrl scd_clock_ctrl_asserts u_chk (
   .REF_CLK(REF_CLK), .RESET_N(RESET_N), .CLK_EN(CLK_EN), .SYSREF(SYSREF),
   .SPI_SCLK(SPI_SCLK), .SPI_CSB_N(SPI_CSB_N), .SPI_SDIO_IN(SPI_SDIO_IN),
   .SPI_SDIO_OUT(SPI_SDIO_OUT), .SPI_SDIO_OE(SPI_SDIO_OE), .DIV_CLK(DIV_CLK),
   .DIV_CE(DIV_CE), .HALF_DLY(HALF_DLY), .FINE_DLY(FINE_DLY), .DP_RESET(DP_RESET),
   .REF_EXT(REF_EXT), .FULL_SCALE(FULL_SCALE)
);
`default_nettype wire

// ### tb/scd_host_model.sv
/* Host on the serial configuration port: read flag, 15-bit address, one byte.
   Assumes clk is REF_CLK and the bench joins both drivers into sdio_wire. */
`default_nettype none
module scd_host_model (
   // Clock and joined data line
   input wire logic clk,
   input wire logic sdio_wire,
   // Serial pins
   output logic sclk,
   output logic csb_n,
   output logic sdio
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      sclk = 1'b0;
      csb_n = 1'b1;
      sdio = 1'b0;
   end
   // Fewer than 24 bits aborts the frame; the clock stands low between frames
   task automatic xfer(input logic rd, input logic [14:0] addr, input logic [7:0] wdata,
                       input int nbits, output logic [7:0] rdata);
      logic [23:0] frame;
      frame = {rd, addr, wdata};
      rdata = 8'h00;
      @(negedge clk);
      csb_n = 1'b0;
      for (int i = 23; i > 23 - nbits; i--) begin
         sclk = 1'b0;
         // Released during read data: toggle so a stale level never looks valid
         sdio = (rd && i < 8) ? ~sdio : frame[i];
         repeat (4) @(negedge clk);
         sclk = 1'b1;
         repeat (4) @(negedge clk);
         if (i < 8) begin
            rdata[i] = sdio_wire;
         end
      end
      sclk = 1'b0;
      csb_n = 1'b1;
      repeat (4) @(negedge clk);
   endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
/* Self-checking bench: register traffic, divider ratios, sync presets, fine delay.
   Assumes the host model and the bound checker are compiled alongside. */
`default_nettype none
module tb
   import scd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, sysref = 1'b0;
   logic sclk, csb_n, host_sdio, sdo, oe, div_clk, div_ce, ref_ext;
   logic [1:0] half_dly, dp_reset, last_dp;
   logic [7:0] full_scale, rd;
   scd_fine_t fine_dly;
   int mismatches = 0;
   int checks = 0;
   int pulses = 0;
   logic [31:0] lfsr_state = 32'hd2cd2e7a;
   wire logic sdio_wire = oe ? sdo : host_sdio;
   always #5 clk = ~clk;
   scd_clock_ctrl dut (
      .REF_CLK(clk), .RESET_N(rst_n), .CLK_EN(clk_en), .SYSREF(sysref),
      .SPI_SCLK(sclk), .SPI_CSB_N(csb_n), .SPI_SDIO_IN(sdio_wire), .SPI_SDIO_OUT(sdo),
      .SPI_SDIO_OE(oe), .DIV_CLK(div_clk), .DIV_CE(div_ce), .HALF_DLY(half_dly),
      .FINE_DLY(fine_dly), .DP_RESET(dp_reset), .REF_EXT(ref_ext), .FULL_SCALE(full_scale)
   );
   scd_host_model host (.clk(clk), .sdio_wire(sdio_wire), .sclk(sclk), .csb_n(csb_n), .sdio(host_sdio));
   // *****
   // Helpers
   // *****
   always @(negedge clk) begin
      if (dp_reset !== 2'h0) begin
         pulses = pulses + 1;
         last_dp = dp_reset;
      end
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      host.xfer(1'b0, a, d, 24, rd);
   endtask
   task automatic rd_chk(input logic [14:0] a, input logic [7:0] exp, input string what);
      host.xfer(1'b1, a, 8'h00, 24, rd);
      check(what, rd, exp);
   endtask
   task automatic wait_ce(output int n);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (div_ce !== 1'b1 && n < 40);
      if (n >= 40) begin
         mismatches++;
         summarize();
      end
   endtask
   initial begin
      repeat (50000) @(negedge clk);
      mismatches++;
      summarize();
   end
   // *****
   // Main sequence
   // *****
   initial begin
      int n, ce_hi, clk_hi;
      logic [7:0] v, w;
      logic [2:0] p;
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      rd_chk(ADDR_DIV_RATIO, RST_DIV_RATIO, "ratio reset");
      for (int c = 3; c >= 0; c--) begin
         wr(ADDR_DIV_RATIO, 8'(c));
         ce_hi = 0;
         clk_hi = 0;
         repeat (32) begin
            @(negedge clk);
            ce_hi += div_ce;
            clk_hi += div_clk;
         end
         check("tick count", 8'(ce_hi), 8'(32 >> c));
         check("high count", 8'(clk_hi), (c == 0) ? 8'h20 : 8'h10);
      end
      rd_chk(ADDR_REF_SEL, RST_REF_SEL, "ref reset");
      rd_chk(ADDR_FULL_SCALE, RST_FULL_SCALE, "range reset");
      rd_chk(15'h0333, 8'h00, "unmapped read");
      pulses = 0;
      repeat (5) begin
         lfsr_state = lfsr(lfsr_state);
         v = lfsr_state[7:0];
         w = lfsr_state[15:8];
         wr(ADDR_REF_SEL, v);
         wr(ADDR_FULL_SCALE, w);
         wr(ADDR_HALF_ADJ, v);
         wr(15'h0777, ~w);
         check("ref select", ref_ext, v[0]);
         check("full scale", full_scale, w);
         check("half delay", half_dly, v[1:0]);
         rd_chk(ADDR_FULL_SCALE, w, "range read");
      end
      check("half pulses", 8'(pulses), 8'h00);
      host.xfer(1'b0, ADDR_FULL_SCALE, ~w, 23, rd);
      check("aborted frame", full_scale, w);
      // Sync presets at ratio 8
      for (int k = 0; k < 4; k++) begin
         lfsr_state = lfsr(lfsr_state);
         p = lfsr_state[2:0];
         wr(ADDR_DIV_RATIO, {1'b1, p, 4'h3});
         sysref = 1'b1;
         @(negedge clk);
         check("preset tick", div_ce, p == 3'h0);
         check("preset level", div_clk, p < 3'h4);
         wait_ce(n);
         check("preset gap", 8'(n), 8'h08 - 8'(p));
         sysref = 1'b0;
      end
      wr(ADDR_DIV_RATIO, 8'h43);
      wait_ce(n);
      sysref = 1'b1;
      wait_ce(n);
      check("sync disabled", 8'(n), 8'h08);
      sysref = 1'b0;
      // Fine delay
      v = lfsr_state[15:8] | 8'h01;
      w = ~v;
      pulses = 0;
      wr(ADDR_FINE_VAL, v);
      check("gated value", fine_dly.value_a, 8'h00);
      wr(ADDR_FINE_EN, 8'h01);
      check("value a", fine_dly.value_a, v);
      check("value b", fine_dly.value_b, v);
      check("enable pulses", 8'(pulses), 8'h01);
      check("pulse lanes", last_dp, 2'h3);
      wr(ADDR_FINE_VAL, w);
      wr(ADDR_FINE_EN, 8'h01);
      wr(ADDR_CHAN_SEL, 8'h01);
      wr(ADDR_FINE_VAL, v);
      check("value a2", fine_dly.value_a, v);
      check("value b2", fine_dly.value_b, w);
      check("no extra pulse", 8'(pulses), 8'h01);
      rd_chk(ADDR_FINE_VAL, v, "fine read");
      wr(ADDR_FINE_EN, 8'h00);
      check("disabled a", fine_dly.value_a, 8'h00);
      check("enables", fine_dly.enable, 2'h2);
      // Frozen divider while the enable is low
      clk_en = 1'b0;
      v = {6'h00, div_clk, div_ce};
      repeat (5) @(negedge clk);
      check("frozen", {div_clk, div_ce}, v[1:0]);
      clk_en = 1'b1;
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      check("reset range", full_scale, RST_FULL_SCALE);
      check("reset half", half_dly, RST_HALF_ADJ);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      check("reset ratio", {div_clk, div_ce}, 2'h3);
      summarize();
   end
endmodule
`default_nettype wire
